// ===== pkg/port_pkg.sv
/*
 * constants, register map and bus carrier of the port latch and
 * pull-up block.
 * assumes a cpu-side request that lasts one clock per access.
 */
package port_pkg;

   localparam int NPORT = 8;
   localparam int NBIT  = 8;

   // order of the slots: ports 0, 1, 2, 3, 4, 6, 7, 12
   localparam logic [15:0] LATCH_ADDR [NPORT] = '{
      16'hFF00, 16'hFF01, 16'hFF02, 16'hFF03,
      16'hFF04, 16'hFF06, 16'hFF07, 16'hFF0C};
   localparam logic [15:0] DIR_ADDR [NPORT] = '{
      16'hFF20, 16'hFF21, 16'hFF22, 16'hFF23,
      16'hFF24, 16'hFF26, 16'hFF27, 16'hFF2C};
   localparam logic [15:0] PULLUP_ADDR [NPORT] = '{
      16'hFF30, 16'hFF31, 16'h0000, 16'hFF33,
      16'hFF34, 16'h0000, 16'hFF37, 16'hFF3C};
   localparam logic PULLUP_PRESENT [NPORT] = '{
      1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1};

   // implemented pin bits per port
   localparam logic [7:0] PIN_MASK [NPORT] = '{
      8'h03, 8'hFF, 8'h0F, 8'h0F, 8'h03, 8'h0F, 8'h03, 8'h07};
   // bits that carry an on-chip pull-up
   localparam logic [7:0] PULLUP_MASK [NPORT] = '{
      8'h03, 8'hFF, 8'h00, 8'h0F, 8'h03, 8'h00, 8'h03, 8'h01};
   // n-channel open-drain bits
   localparam logic [7:0] OPEN_DRAIN_MASK [NPORT] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};

   localparam int         CLK_PORT_IDX  = 7;
   localparam logic [7:0] CLK_PIN_MASK  = 8'h06;

   localparam logic [7:0] LATCH_RESET   = 8'h00;
   localparam logic [7:0] PULLUP_RESET  = 8'h00;
   localparam logic [7:0] DIR_RESET     = 8'hFF;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   typedef enum logic [1:0] {
      KIND_NONE   = 2'b00,
      KIND_LATCH  = 2'b01,
      KIND_DIR    = 2'b10,
      KIND_PULLUP = 2'b11
   } reg_kind_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
      logic        bit_op;
      logic [2:0]  bit_sel;
   } cpu_req_t;

endpackage

// ===== hdl/port_regs.sv
/*
 * port output latches and direction selects for eight gpio ports, pull-up
 * options for six of them, with pin drive, pin enable and pull-up controls.
 * assumes a cpu that issues one-clock read or write requests and pins
 * that arrive asynchronously to CLK.
 */
// Notes on behaviour
// RL1: output-mode pins driven from latch bit
// RL2: input-mode bits read the live pin
// RL3: output-mode bits read the stored latch
// RL4: bit and byte writes both accepted
// RL5: reset clears latches and pull-up options
// RL6: clock pins read zero in external-clock mode
// RL7: software writes zero to unimplemented latch bits
// RL8: pull-up only when bit set and input
// RL9: no pull-up on outputs or alternate outputs
// RL10: pull-up bit one connects, zero disconnects
// RL11: direction zero drives, one makes input
// RL12: reset sets all direction bits to one
// RL13: input-mode latch write leaves pin untouched
// RL14: bit write on input uses pin level
// RL15: unimplemented bits read zero, ignore writes; direction registers read them as one
module port_regs
(
   input  wire logic                 CLK,
   input  wire logic                 RST,
   input  wire port_pkg::cpu_req_t   CPU_REQ,
   input  wire logic                 EXT_CLK_MODE,
   input  wire logic [7:0][7:0]      ALT_OUT,
   input  wire logic [7:0][7:0]      PIN_IN,
   output logic [7:0]                RDATA,
   output logic                      RVALID,
   output logic [7:0][7:0]           PIN_OUT,
   output logic [7:0][7:0]           PIN_OE,
   output logic [7:0][7:0]           PULLUP_EN
);

   ////////////////////////////////////////////////////////////////////
   // state

   logic [7:0] latch_q  [port_pkg::NPORT];
   logic [7:0] dir_q    [port_pkg::NPORT];
   logic [7:0] pullup_q [port_pkg::NPORT];

   logic [7:0][7:0] sync1_q;
   logic [7:0][7:0] sync2_q;
   logic [7:0][7:0] sync3_q;
   logic [7:0][7:0] pin_q;
   logic [7:0][7:0] pin_d;

   port_pkg::reg_kind_t kind;
   logic [2:0]          slot;
   logic [7:0]          cur_val;
   logic [7:0]          new_val;
   logic [7:0]          rd_view [port_pkg::NPORT];

   ////////////////////////////////////////////////////////////////////
   // pin input: three stages, a change counts once stages 2 and 3 agree

   // stage one may go metastable, so only stage two reads it
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         sync1_q <= '0;
      end
      else
      begin
         sync1_q <= PIN_IN;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         sync2_q <= '0;
      end
      else
      begin
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         sync3_q <= '0;
      end
      else
      begin
         sync3_q <= sync2_q;
      end
   end

   // a single disagreeing sample is held off, filtering one-clock glitches
   always_comb
   begin
      for (int i = 0; i < port_pkg::NPORT; i++)
      begin
         pin_d[i] = (~(sync2_q[i] ^ sync3_q[i]) & sync3_q[i])
                  | ((sync2_q[i] ^ sync3_q[i]) & pin_q[i]);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         pin_q <= '0;
      end
      else
      begin
         pin_q <= pin_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // latch read view, pin for inputs and latch for outputs

   always_comb
   begin
      for (int i = 0; i < port_pkg::NPORT; i++)
      begin
         rd_view[i] = ((dir_q[i] & pin_q[i])         // RL2
                    | (~dir_q[i] & latch_q[i]))      // RL3
                    & port_pkg::PIN_MASK[i];         // RL15
         if (i == port_pkg::CLK_PORT_IDX && EXT_CLK_MODE)
         begin
            rd_view[i] = rd_view[i] & ~port_pkg::CLK_PIN_MASK; // RL6
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // address decode

   always_comb
   begin
      kind = port_pkg::KIND_NONE;
      slot = 3'h0;
      for (int i = 0; i < port_pkg::NPORT; i++)
      begin
         if (CPU_REQ.addr == port_pkg::LATCH_ADDR[i])
         begin
            kind = port_pkg::KIND_LATCH;
            slot = i[2:0];
         end
         else if (CPU_REQ.addr == port_pkg::DIR_ADDR[i])
         begin
            kind = port_pkg::KIND_DIR;
            slot = i[2:0];
         end
         else if (port_pkg::PULLUP_PRESENT[i]
                  && CPU_REQ.addr == port_pkg::PULLUP_ADDR[i])
         begin
            kind = port_pkg::KIND_PULLUP;
            slot = i[2:0];
         end
      end
   end

   // current readable value of the addressed register
   always_comb
   begin
      case (kind)
         port_pkg::KIND_LATCH:
            cur_val = rd_view[slot];
         port_pkg::KIND_DIR:
            cur_val = dir_q[slot] | ~port_pkg::PIN_MASK[slot];
         port_pkg::KIND_PULLUP:
            cur_val = pullup_q[slot] & port_pkg::PULLUP_MASK[slot]; // RL15
         default:
            cur_val = port_pkg::RDATA_UNMAPPED;
      endcase
   end

   // bit writes merge into the read view, so an input-mode bit
   // instruction copies pin levels into the latch
   always_comb
   begin
      new_val = CPU_REQ.wdata;
      if (CPU_REQ.bit_op)
      begin
         new_val = cur_val;                          // RL14
         new_val[CPU_REQ.bit_sel] = CPU_REQ.wdata[0]; // RL4
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register writes

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         for (int i = 0; i < port_pkg::NPORT; i++)
         begin
            latch_q[i] <= port_pkg::LATCH_RESET;     // RL5
         end
      end
      else if (CPU_REQ.wr && kind == port_pkg::KIND_LATCH)
      begin
         // stored in any mode; the pin follows only in output mode
         latch_q[slot] <= new_val & port_pkg::PIN_MASK[slot]; // RL13
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         for (int i = 0; i < port_pkg::NPORT; i++)
         begin
            dir_q[i] <= port_pkg::DIR_RESET;         // RL12
         end
      end
      else if (CPU_REQ.wr && kind == port_pkg::KIND_DIR)
      begin
         dir_q[slot] <= new_val | ~port_pkg::PIN_MASK[slot];
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         for (int i = 0; i < port_pkg::NPORT; i++)
         begin
            pullup_q[i] <= port_pkg::PULLUP_RESET;   // RL5
         end
      end
      else if (CPU_REQ.wr && kind == port_pkg::KIND_PULLUP)
      begin
         pullup_q[slot] <= new_val & port_pkg::PULLUP_MASK[slot]; // RL4
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read answer, one clock after the request

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         RVALID <= '0;
      end
      else
      begin
         RVALID <= CPU_REQ.rd;
      end
   end

   // data stands until the next read, so a late look still sees it
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         RDATA <= port_pkg::RDATA_UNMAPPED;
      end
      else if (CPU_REQ.rd)
      begin
         RDATA <= cur_val;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin controls, registered, so they trail register writes by a clock

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         PIN_OUT <= '0;
      end
      else
      begin
         for (int i = 0; i < port_pkg::NPORT; i++)
         begin
            PIN_OUT[i] <= latch_q[i] & port_pkg::PIN_MASK[i]; // RL1
         end
      end
   end

   // open-drain bits only sink, so they drive on a zero
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         PIN_OE <= '0;
      end
      else
      begin
         for (int i = 0; i < port_pkg::NPORT; i++)
         begin
            PIN_OE[i] <= ~dir_q[i] & port_pkg::PIN_MASK[i]    // RL11
                       & ~(port_pkg::OPEN_DRAIN_MASK[i] & latch_q[i]);
         end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         PULLUP_EN <= '0;
      end
      else
      begin
         for (int i = 0; i < port_pkg::NPORT; i++)
         begin
            PULLUP_EN[i] <= pullup_q[i] & dir_q[i]            // RL8 RL10
                          & ~ALT_OUT[i]                       // RL9
                          & port_pkg::PULLUP_MASK[i];
         end
      end
   end

endmodule

// ===== verification/port_regs_assertions.sv
/*
 * checker for the port latch and pull-up block.
 * assumes one clock and a synchronous active-high reset.
 */
module port_regs_assertions
(
   input wire logic                CLK,
   input wire logic                RST,
   input wire port_pkg::cpu_req_t  CPU_REQ,
   input wire logic                EXT_CLK_MODE,
   input wire logic [7:0][7:0]     ALT_OUT,
   input wire logic [7:0][7:0]     PIN_IN,
   input wire logic [7:0]          RDATA,
   input wire logic                RVALID,
   input wire logic [7:0][7:0]     PIN_OUT,
   input wire logic [7:0][7:0]     PIN_OE,
   input wire logic [7:0][7:0]     PULLUP_EN
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);
   ////////////////////////////////////////
   AST_RD_ANSWER: assert property (CPU_REQ.rd |=> RVALID)
      else $error("read not answered next cycle");
   AST_NO_PULSE: assert property (!CPU_REQ.rd |=> !RVALID)
      else $error("read valid without a read");
   AST_RDATA_HOLD: assert property
      (!$past(CPU_REQ.rd) |-> $stable(RDATA))
      else $error("read data moved without a read");
   AST_RESET_OUT: assert property
      ($fell(RST) |-> PIN_OE == '0 && PULLUP_EN == '0 && PIN_OUT == '0)
      else $error("outputs not cleared by reset");
   AST_PU_OUT: assert property ((PULLUP_EN & PIN_OE) == '0)
      else $error("pull-up on a driven pin");
   AST_PU_ALT: assert property ((PULLUP_EN & $past(ALT_OUT)) == '0)
      else $error("pull-up on an alternate output");
   AST_PU_NONE: assert property
      (PULLUP_EN[2] == 8'h00 && PULLUP_EN[5] == 8'h00)
      else $error("pull-up on a port without one");
   AST_OE_MASK: assert property
      (PIN_OE[0][7:2] == 6'h00 && PIN_OE[7][7:3] == 5'h00)
      else $error("enable on a missing pin");
   // in external-clock mode the clock pins belong to the oscillator, not the latch
   AST_CLK_PINS: assert property
      (CPU_REQ.rd && CPU_REQ.addr == 16'hFF0C && EXT_CLK_MODE
       |=> RDATA[2:1] == 2'h0)
      else $error("clock pins not read as zero");
   AST_UNMAPPED: assert property
      (CPU_REQ.rd && CPU_REQ.addr == 16'hFF32 |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   AST_OE_WRITE: assert property
      (CPU_REQ.wr && !CPU_REQ.bit_op && CPU_REQ.addr == 16'hFF21
       && CPU_REQ.wdata == 8'h00 |-> ##2 PIN_OE[1] == 8'hFF)
      else $error("output mode not driving");
endmodule
////////////////////////////////////////
bind port_regs port_regs_assertions watch
(
   .CLK(CLK), .RST(RST), .CPU_REQ(CPU_REQ), .EXT_CLK_MODE(EXT_CLK_MODE),
   .ALT_OUT(ALT_OUT), .PIN_IN(PIN_IN), .RDATA(RDATA), .RVALID(RVALID),
   .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PULLUP_EN(PULLUP_EN)
);

// ===== verification/test_port_regs.sv
/*
 * self-checking bench for the port latch and pull-up block.
 * assumes the package and the design are compiled first.
 */
module test_port_regs;
   timeunit 1ns;
   timeprecision 100ps;
   ////////////////////////////////////////
   logic               clk;
   logic               rst;
   port_pkg::cpu_req_t req;
   logic               ext_mode;
   logic [7:0][7:0]    alt_out;
   logic [7:0][7:0]    pin_in;
   logic [7:0]         rdata;
   logic               rvalid;
   logic [7:0][7:0]    pin_out;
   logic [7:0][7:0]    pin_oe;
   logic [7:0][7:0]    pullup_en;
   int                 err_count = 0;
   int                 check_count = 0;

   port_regs dut
   (
      .CLK(clk), .RST(rst), .CPU_REQ(req), .EXT_CLK_MODE(ext_mode),
      .ALT_OUT(alt_out), .PIN_IN(pin_in), .RDATA(rdata), .RVALID(rvalid),
      .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULLUP_EN(pullup_en)
   );

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // one access, then an idle cycle so strobes never merge
   task automatic acc(input logic [15:0] a, input logic [7:0] d,
                      input logic w, input logic b, input logic [2:0] s,
                      input logic [7:0] e);
      @(posedge clk);
      req <= '{a, d, w, !w, b, s};
      @(posedge clk);
      req <= '0;
      #1;
      if (!w)
      begin
         chk(rdata, e);
         chk({7'h00, rvalid}, 8'h01);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      acc(a, d, 1'b1, 1'b0, 3'h0, 8'h00);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      acc(a, 8'h00, 1'b0, 1'b0, 3'h0, e);
   endtask

   // covers the four-edge pin filter and the output flop
   task automatic settle;
      repeat (5) @(posedge clk);
      #1;
   endtask

   task automatic final_report;
      if (err_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      req = '0;
      ext_mode = 1'b0;
      alt_out = '0;
      pin_in = '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < port_pkg::NPORT; i++)
      begin
         rd(port_pkg::LATCH_ADDR[i], 8'h00);
         rd(port_pkg::DIR_ADDR[i], 8'hFF);
         if (port_pkg::PULLUP_PRESENT[i])
            rd(port_pkg::PULLUP_ADDR[i], 8'h00);
      end
      wr(16'hFF01, 8'hA5);
      @(posedge clk);
      pin_in[1] <= 8'h3C;
      settle();
      chk(pin_oe[1], 8'h00);
      rd(16'hFF01, 8'h3C);
      wr(16'hFF21, 8'h0F);
      settle();
      chk(pin_oe[1], 8'hF0);
      chk(pin_out[1] & 8'hF0, 8'hA0);
      rd(16'hFF01, 8'hAC);
      acc(16'hFF01, 8'h00, 1'b1, 1'b1, 3'h7, 8'h00);
      wr(16'hFF21, 8'h00);
      settle();
      chk(pin_out[1], 8'h2C);
      wr(16'hFF20, 8'h00);
      wr(16'hFF00, 8'h03);
      rd(16'hFF00, 8'h03);
      wr(16'hFF30, 8'hFF);
      rd(16'hFF30, 8'h03);
      wr(16'hFF26, 8'hF0);
      settle();
      chk(pin_oe[5], 8'h0F);
      wr(16'hFF06, 8'h01);
      settle();
      chk(pin_oe[5], 8'h0E);
      chk(pin_out[5], 8'h01);
      wr(16'hFF32, 8'hFF);
      rd(16'hFF32, 8'h00);
      wr(16'hFF31, 8'h0F);
      rd(16'hFF31, 8'h0F);
      settle();
      chk(pullup_en[1], 8'h00);
      wr(16'hFF21, 8'hFF);
      @(posedge clk);
      alt_out[1] <= 8'h01;
      settle();
      chk(pullup_en[1], 8'h0E);
      acc(16'hFF31, 8'h01, 1'b1, 1'b1, 3'h7, 8'h00);
      rd(16'hFF31, 8'h8F);
      settle();
      chk(pullup_en[1], 8'h8E);
      @(posedge clk);
      pin_in[7] <= 8'h07;
      ext_mode <= 1'b1;
      settle();
      rd(16'hFF0C, 8'h01);
      @(posedge clk);
      ext_mode <= 1'b0;
      rd(16'hFF0C, 8'h07);
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(16'hFF31, 8'h00);
      rd(16'hFF21, 8'hFF);
      rd(16'hFF01, 8'h3C);
      final_report();
   end

   // over six times the expected run
   initial
   begin
      #4000;
      err_count++;
      final_report();
   end
endmodule
